// ---- rtl/crc_params.svh ----
`ifndef CRC_PARAMS_SVH
`define CRC_PARAMS_SVH

// Register byte offsets on the bus
`define CRC_OFF_CTRL0 8'h00
`define CRC_OFF_CTRL1 8'h04
`define CRC_OFF_DATH 8'h08
`define CRC_OFF_DATL 8'h0c
`define CRC_OFF_ACCH 8'h10
`define CRC_OFF_ACCL 8'h14
`define CRC_OFF_SHFH 8'h18
`define CRC_OFF_SHFL 8'h1c
`define CRC_OFF_XORH 8'h20
`define CRC_OFF_XORL 8'h24

// Control register 0 bit positions
`define CRC_BIT_EN 7
`define CRC_BIT_RUN 6
`define CRC_BIT_BUSY 5
`define CRC_BIT_AUGMENT 4
`define CRC_BIT_ORDER 1
`define CRC_BIT_FULL 0

// Control register 1 fields
`define CRC_WSIZE_HI 7
`define CRC_WSIZE_LO 4
`define CRC_PSIZE_HI 3
`define CRC_PSIZE_LO 0

`define CRC_CTRL0_RST 8'h00
`define CRC_CTRL1_RST 8'h00
`define CRC_WORD_RST 16'h0000
`define CRC_XOR_RST 15'h0000
`define CRC_CNT_RST 4'h0

`define CRC_HTRANS_NONSEQ 2'b10
`define CRC_HRESP_OKAY 1'b0

`endif

// ---- rtl/crc_pkg.sv ----
package crc_pkg;
	typedef struct packed {
		logic en;
		logic run;
		logic augment_select;
		logic right;
	} ctrl0_type;

	typedef struct packed {
		logic [3:0] input_word_size;
		logic [3:0] polynomial_size;
	} ctrl1_type;

	typedef struct packed {
		logic sel;
		logic write;
		logic [7:0] addr;
	} ahb_req_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SHIFT = 2'b10
	} shift_state_type;
endpackage

// ---- rtl/crc_step.sv ----
`timescale 1ns/1ps
// One serial step of the remainder, for either bit order and either mode
module crc_step (
	input wire logic [15:0] acc,
	input wire logic [15:0] poly,
	input wire logic din,
	input wire logic [3:0] polynomial_size,
	input wire logic augment_select,
	input wire logic right,
	output logic [15:0] acc_next
);
	logic [15:0] mask;
	logic [15:0] poly_ref;
	logic [15:0] sh;
	logic fb;

	always_comb begin
		mask = 16'h0000;
		poly_ref = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (4'(i) <= polynomial_size) begin
				mask[i] = 1'b1;
				poly_ref[i] = poly[polynomial_size - 4'(i)];
			end
		end
		if (right) begin
			// Augmented mode feeds the bit in with the feedback
			fb = augment_select ? (acc[0] ^ din) : acc[0];
			sh = acc >> 1;
			if (!augment_select) begin
				sh[polynomial_size] = din;
			end
			acc_next = (sh ^ (fb ? poly_ref : 16'h0000)) & mask;
		end else begin
			fb = augment_select ? (acc[polynomial_size] ^ din) : acc[polynomial_size];
			sh = {acc[14:0], augment_select ? 1'b0 : din};
			acc_next = (sh ^ (fb ? poly : 16'h0000)) & mask;
		end
	end
endmodule

// ---- rtl/crc_engine_control.sv ----
`timescale 1ns/1ps
`include "crc_params.svh"
// Function
// RQ1 - Run bit starts serial shifting; clearing it stops the shifter.
// RQ2 - Shift mode bit 1 shifts right, 0 shifts left.
// RQ3 - Bits 7-4 of control 1 hold word length minus one; that many plus one bits.
// RQ4 - Bits 3-0 of control 1 hold polynomial length minus one; sets CRC width.
// RQ5 - Augment bit chooses augmented or non-augmented accumulation.
// RQ6 - Writing the input low byte loads the word toward the shifter.
// RQ7 - Input word is 16 bits, high and low bytes read/write, reset unknown.
// RQ8 - Control 0 bits 3-2 ignore writes and read zero.
// RQ9 - Implemented control bits clear to zero on every reset.
// RQ10 - Control 0: enable 7, run 6, busy 5, augment 4, order 1, full 0.
// RQ11 - Busy reads 1 while shifting or data pending, else 0.
// RQ12 - Full reads 1 while a word waits for the shifter.
// RQ13 - 16-bit accumulator read/write as two bytes, resets to zero.
// RQ14 - Shifter contents readable as two read-only bytes, reset zero.
// RQ15 - Tap mask enables terms 15 to 1; bit 0 reads one, always present.
module crc_engine_control (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp
);
	import crc_pkg::*;

	crc_pkg::ctrl0_type ctrl0_q;
	crc_pkg::ctrl1_type ctrl1_q;
	crc_pkg::ahb_req_type req_q;
	crc_pkg::shift_state_type state_q;
	logic [15:0] word_q;
	logic full_q;
	logic [15:0] acc_q;
	logic [15:0] acc_step;
	logic [15:0] shift_q;
	logic [3:0] cnt_q;
	logic [15:1] xor_q;
	logic [31:0] hrdata_q;
	logic [7:0] wbyte;
	logic accept;
	logic load;
	logic step;
	logic din;
	logic busy;
	logic [15:0] poly;

	// Single word transfers only; hsize is accepted as given
	assign accept = hsel && hready && (htrans == `CRC_HTRANS_NONSEQ);
	assign wbyte = hwdata[7:0];
	// Zero wait states keep the slave simple; every transfer ends in one data phase
	assign hreadyout = 1'b1;
	assign hresp = `CRC_HRESP_OKAY;
	assign hrdata = hrdata_q;

	assign poly = {xor_q, 1'b1}; // [RQ15]
	assign load = ctrl0_q.en && ctrl0_q.run && full_q && (state_q == ST_IDLE); // [RQ1]
	assign step = ctrl0_q.en && ctrl0_q.run && (state_q == ST_SHIFT); // [RQ1]
	// Left takes the top bit of the word, right takes bit 0
	assign din = ctrl0_q.right ? shift_q[0] : shift_q[ctrl1_q.input_word_size]; // [RQ2] [RQ3]
	assign busy = full_q || (state_q == ST_SHIFT); // [RQ11]

	function automatic logic is_wr(input crc_pkg::ahb_req_type r, input logic [7:0] off);
		is_wr = r.sel && r.write && (r.addr == off);
	endfunction

	function automatic logic [7:0] rd_mux(input logic [7:0] off);
		case (off)
			`CRC_OFF_CTRL0: begin
				// Bits 3-2 are tied low
				rd_mux = {ctrl0_q.en, ctrl0_q.run, busy, ctrl0_q.augment_select, 2'b00,
					ctrl0_q.right, full_q}; // [RQ8] [RQ10] [RQ12]
			end
			`CRC_OFF_CTRL1: rd_mux = {ctrl1_q.input_word_size, ctrl1_q.polynomial_size};
			`CRC_OFF_DATH: rd_mux = word_q[15:8];
			`CRC_OFF_DATL: rd_mux = word_q[7:0];
			`CRC_OFF_ACCH: rd_mux = acc_q[15:8]; // [RQ13]
			`CRC_OFF_ACCL: rd_mux = acc_q[7:0];
			`CRC_OFF_SHFH: rd_mux = shift_q[15:8]; // [RQ14]
			`CRC_OFF_SHFL: rd_mux = shift_q[7:0];
			`CRC_OFF_XORH: rd_mux = xor_q[15:8];
			`CRC_OFF_XORL: rd_mux = {xor_q[7:1], 1'b1}; // [RQ15]
			default: rd_mux = 8'h00;
		endcase
	endfunction

	crc_step u_step (
		.acc(acc_q),
		.poly(poly),
		.din(din),
		.polynomial_size(ctrl1_q.polynomial_size), // [RQ4]
		.augment_select(ctrl0_q.augment_select), // [RQ5]
		.right(ctrl0_q.right), // [RQ2]
		.acc_next(acc_step)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q <= '0;
		end else if (hready) begin
			req_q <= '{sel: accept, write: hwrite, addr: haddr[7:0]};
		end
	end

	// Read data is sampled at the address phase, before a write in flight lands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (accept && !hwrite) begin
			hrdata_q <= {24'h00_0000, rd_mux(haddr[7:0])};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl0_q <= '0; // [RQ9]
			ctrl1_q <= '0; // [RQ9]
		end else begin
			if (is_wr(req_q, `CRC_OFF_CTRL0)) begin
				ctrl0_q <= '{en: wbyte[`CRC_BIT_EN], run: wbyte[`CRC_BIT_RUN],
					augment_select: wbyte[`CRC_BIT_AUGMENT], right: wbyte[`CRC_BIT_ORDER]}; // [RQ10]
			end
			if (is_wr(req_q, `CRC_OFF_CTRL1)) begin
				ctrl1_q <= '{input_word_size: wbyte[`CRC_WSIZE_HI:`CRC_WSIZE_LO],
					polynomial_size: wbyte[`CRC_PSIZE_HI:`CRC_PSIZE_LO]}; // [RQ3] [RQ4]
			end
		end
	end

	// No reset: the input word powers up unknown
	always_ff @(posedge hclk) begin
		if (is_wr(req_q, `CRC_OFF_DATH)) begin
			word_q[15:8] <= wbyte; // [RQ7]
		end
		if (is_wr(req_q, `CRC_OFF_DATL)) begin
			word_q[7:0] <= wbyte; // [RQ7]
		end
	end

	// A new low byte write wins over the transfer in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			full_q <= 1'b0;
		end else if (is_wr(req_q, `CRC_OFF_DATL)) begin
			full_q <= 1'b1; // [RQ6] [RQ12]
		end else if (load) begin
			full_q <= 1'b0; // [RQ12]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= ST_IDLE;
			shift_q <= `CRC_WORD_RST;
			cnt_q <= `CRC_CNT_RST;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (load) begin
						state_q <= ST_SHIFT;
						shift_q <= word_q; // [RQ6]
						cnt_q <= ctrl1_q.input_word_size; // [RQ3]
					end
				end
				ST_SHIFT: begin
					if (step) begin
						shift_q <= ctrl0_q.right ? (shift_q >> 1) : (shift_q << 1); // [RQ2]
						cnt_q <= cnt_q - 4'h1;
						if (cnt_q == `CRC_CNT_RST) begin
							state_q <= ST_IDLE; // [RQ3] [RQ11]
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Software write to the accumulator overrides a shift step in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= `CRC_WORD_RST; // [RQ13]
		end else if (is_wr(req_q, `CRC_OFF_ACCH)) begin
			acc_q[15:8] <= wbyte; // [RQ13]
		end else if (is_wr(req_q, `CRC_OFF_ACCL)) begin
			acc_q[7:0] <= wbyte; // [RQ13]
		end else if (step) begin
			acc_q <= acc_step; // [RQ5]
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xor_q <= `CRC_XOR_RST;
		end else begin
			if (is_wr(req_q, `CRC_OFF_XORH)) begin
				xor_q[15:8] <= wbyte; // [RQ15]
			end
			if (is_wr(req_q, `CRC_OFF_XORL)) begin
				xor_q[7:1] <= wbyte[7:1]; // [RQ15]
			end
		end
	end

	// Checks
	sequence s_load;
		load;
	endsequence

	sequence s_shift_done;
		(state_q == ST_SHIFT) [*1] ##1 (state_q == ST_IDLE);
	endsequence

	property p_run_off_hold;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_SHIFT && !ctrl0_q.run) |=> $stable(shift_q) && $stable(cnt_q);
	endproperty
	a_run_off_hold: assert property (p_run_off_hold) // [RQ1]
		else $error("shifter moved with run clear");

	// A paused word must not leak into the remainder
	property p_run_off_acc;
		@(posedge hclk) disable iff (!hresetn)
		(state_q == ST_SHIFT && !ctrl0_q.run && !is_wr(req_q, `CRC_OFF_ACCH)
			&& !is_wr(req_q, `CRC_OFF_ACCL)) |=> $stable(acc_q);
	endproperty
	a_run_off_acc: assert property (p_run_off_acc) // [RQ1]
		else $error("remainder moved with run clear");

	property p_left_order;
		@(posedge hclk) disable iff (!hresetn)
		(step && !ctrl0_q.right) |=> shift_q == ($past(shift_q) << 1);
	endproperty
	a_left_order: assert property (p_left_order) // [RQ2]
		else $error("left shift wrong");

	property p_right_order;
		@(posedge hclk) disable iff (!hresetn)
		(step && ctrl0_q.right) |=> shift_q == ($past(shift_q) >> 1);
	endproperty
	a_right_order: assert property (p_right_order) // [RQ2]
		else $error("right shift wrong");

	property p_word_len;
		@(posedge hclk) disable iff (!hresetn)
		s_load |=> (cnt_q == $past(ctrl1_q.input_word_size)) && (shift_q == $past(word_q));
	endproperty
	a_word_len: assert property (p_word_len) // [RQ3]
		else $error("load did not take word and length");

	property p_last_bit;
		@(posedge hclk) disable iff (!hresetn)
		(step && cnt_q == `CRC_CNT_RST) |-> s_shift_done;
	endproperty
	a_last_bit: assert property (p_last_bit) // [RQ3]
		else $error("shift did not end after last bit");

	property p_aug_zero;
		@(posedge hclk) disable iff (!hresetn)
		(step && ctrl0_q.augment_select && acc_q == 16'h0000 && !din
			&& !is_wr(req_q, `CRC_OFF_ACCH) && !is_wr(req_q, `CRC_OFF_ACCL))
			|=> acc_q == 16'h0000;
	endproperty
	a_aug_zero: assert property (p_aug_zero) // [RQ5]
		else $error("augmented zero step changed remainder");

	property p_low_fills;
		@(posedge hclk) disable iff (!hresetn)
		is_wr(req_q, `CRC_OFF_DATL) |=> full_q && busy;
	endproperty
	a_low_fills: assert property (p_low_fills) // [RQ6]
		else $error("low byte write did not set full");

	property p_load_empties;
		@(posedge hclk) disable iff (!hresetn)
		(load && !is_wr(req_q, `CRC_OFF_DATL)) |=> !full_q && (state_q == ST_SHIFT);
	endproperty
	a_load_empties: assert property (p_load_empties) // [RQ12]
		else $error("full not cleared on transfer");

	property p_unimpl_zero;
		@(posedge hclk) disable iff (!hresetn)
		(accept && !hwrite && haddr[7:0] == `CRC_OFF_CTRL0)
			|=> hrdata[3:2] == 2'b00 && hrdata[5] == $past(busy);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) // [RQ8]
		else $error("control 0 read wrong");

	property p_busy_idle;
		@(posedge hclk) disable iff (!hresetn)
		(!full_q && state_q == ST_IDLE) |-> !busy;
	endproperty
	a_busy_idle: assert property (p_busy_idle) // [RQ11]
		else $error("busy high with nothing pending");

	property p_xor_lsb;
		@(posedge hclk) disable iff (!hresetn)
		(accept && !hwrite && haddr[7:0] == `CRC_OFF_XORL) |=> hrdata[0];
	endproperty
	a_xor_lsb: assert property (p_xor_lsb) // [RQ15]
		else $error("tap bit 0 read as zero");
endmodule

// ---- dv/crc_engine_control_tb_top.sv ----
`timescale 1ns/1ps
`include "crc_params.svh"
module crc_engine_control_tb_top;
	import crc_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	integer n_fail, n_tests, k, i;
	logic [7:0] q, m, c1;
	logic [15:0] e, w, a, s;
	logic [47:0] tc [0:4];
	assign hready = hreadyout;
	crc_engine_control u_crc_engine_control (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	task test_done;
		if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task bump;
		n_fail = n_fail + 1;
		test_done;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wait_rdy;
		integer j;
		j = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			j = j + 1;
			if (j > 50) bump;
			@(posedge hclk);
		end
	endtask
	// Leading edge leaves one idle cycle, so a read never sees a stale write
	task bus(input logic [7:0] ad, input logic is_write, input logic [7:0] d,
		output logic [7:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, ad};
		htrans <= `CRC_HTRANS_NONSEQ;
		hwrite <= is_write;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		wait_rdy;
		r = hrdata[7:0];
	endtask
	task wr(input logic [7:0] ad, input logic [7:0] d);
		bus(ad, 1'b1, d, q);
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] exp);
		bus(ad, 1'b0, 8'h00, q);
		chk(q, exp);
	endtask
	task chk_reset;
		rd(`CRC_OFF_CTRL0, `CRC_CTRL0_RST);
		rd(`CRC_OFF_CTRL1, `CRC_CTRL1_RST);
		rd(`CRC_OFF_ACCH, 8'h00);
		rd(`CRC_OFF_ACCL, 8'h00);
		rd(`CRC_OFF_SHFH, 8'h00);
		rd(`CRC_OFF_SHFL, 8'h00);
		rd(`CRC_OFF_XORL, 8'h01);
	endtask
	// Bench model of the remainder; poly 0x81 is its own mirror at 8 bits
	function automatic logic [15:0] crc_ref(input logic [7:0] md, input logic [7:0] cf,
		input logic [15:0] wd, input logic [15:0] ac);
		logic [15:0] p, r, mk;
		logic b, fb;
		int n, x;
		p = 16'h0081;
		n = cf[3:0] + 1;
		mk = 16'hffff >> (16 - n);
		r = 16'h0000;
		for (x = 0; x < n; x++) r[x] = p[n - 1 - x];
		for (x = 0; x <= cf[7:4]; x++) begin
			b = md[1] ? wd[x] : wd[cf[7:4] - x];
			if (!md[1]) begin
				fb = ac[n - 1] ^ (md[4] & b);
				ac = (ac << 1) | {15'h0000, b & ~md[4]};
				if (fb) ac = ac ^ p;
			end else begin
				fb = ac[0] ^ (md[4] & b);
				ac = (ac >> 1) | ({15'h0000, b & ~md[4]} << (n - 1));
				if (fb) ac = ac ^ r;
			end
			ac = ac & mk;
		end
		return ac;
	endfunction
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		n_fail = 0;
		n_tests = 0;
		// Mode bits, control 1, input word, starting remainder
		tc[0] = 48'h00_77_5ac3_0000;
		tc[1] = 48'h10_77_00a7_003c;
		tc[2] = 48'h02_77_1234_0055;
		tc[3] = 48'h12_77_00f0_000f;
		tc[4] = 48'h10_37_00f2_0000;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk_reset;
		wr(`CRC_OFF_CTRL0, 8'hff);
		rd(`CRC_OFF_CTRL0, 8'hd2);
		wr(`CRC_OFF_CTRL1, 8'ha5);
		rd(`CRC_OFF_CTRL1, 8'ha5);
		wr(`CRC_OFF_DATH, 8'h3c);
		rd(`CRC_OFF_DATH, 8'h3c);
		rd(`CRC_OFF_CTRL0, 8'hd2);
		wr(`CRC_OFF_SHFH, 8'hff);
		rd(`CRC_OFF_SHFH, 8'h00);
		wr(`CRC_OFF_ACCH, 8'h1e);
		rd(`CRC_OFF_ACCH, 8'h1e);
		wr(`CRC_OFF_XORH, 8'h12);
		wr(`CRC_OFF_XORL, 8'h34);
		rd(`CRC_OFF_XORH, 8'h12);
		rd(`CRC_OFF_XORL, 8'h35);
		rd(8'h28, 8'h00);
		wr(`CRC_OFF_XORH, 8'h00);
		wr(`CRC_OFF_XORL, 8'h80);
		for (k = 0; k < 5; k++) begin
			{m, c1, w, a} = tc[k];
			wr(`CRC_OFF_CTRL0, 8'h80 | m);
			wr(`CRC_OFF_CTRL1, c1);
			wr(`CRC_OFF_ACCH, a[15:8]);
			wr(`CRC_OFF_ACCL, a[7:0]);
			wr(`CRC_OFF_DATH, w[15:8]);
			wr(`CRC_OFF_DATL, w[7:0]);
			rd(`CRC_OFF_DATL, w[7:0]);
			rd(`CRC_OFF_CTRL0, 8'ha1 | m);
			wr(`CRC_OFF_CTRL0, 8'hc0 | m);
			// Two steps run before the stop lands; the shifter must then stand
			wr(`CRC_OFF_CTRL0, 8'h80 | m);
			s = m[1] ? (w >> 2) : (w << 2);
			rd(`CRC_OFF_CTRL0, 8'ha0 | m);
			rd(`CRC_OFF_SHFL, s[7:0]);
			rd(`CRC_OFF_SHFH, s[15:8]);
			wr(`CRC_OFF_CTRL0, 8'hc0 | m);
			i = 0;
			q = 8'hff;
			while (q[5] !== 1'b0) begin
				i = i + 1;
				if (i > 20) bump;
				bus(`CRC_OFF_CTRL0, 1'b0, 8'h00, q);
			end
			rd(`CRC_OFF_CTRL0, 8'hc0 | m);
			e = crc_ref(m, c1, w, a);
			rd(`CRC_OFF_ACCL, e[7:0]);
			rd(`CRC_OFF_ACCH, e[15:8]);
		end
		// Reset lands on the same edge that loads a 16-bit word into the shifter
		wr(`CRC_OFF_CTRL1, 8'hff);
		wr(`CRC_OFF_DATL, 8'h55);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		chk_reset;
		test_done;
	end
endmodule
